// >>> logic/shared_pin_function_select.sv
// Top of the shared pin function selector
`timescale 1ns/1ps
// Notes on behaviour
// R01: Address-18 pin after reset; timer pulse when either timer control bit set.
// R02: Serial-0 clock after reset; DMA request once destination or source mode bit set.
// R03: Serial-1 clock after reset; transfer-end output when clock-disable bit is one.
// R04: Receive data after reset; clear-to-send input when its enable bit is one.
// R05: Active-low transfer end driven during last write of a DMA block.
// R06: Timer function carries reload timer channel 1 pulse waveform.
// R07: Pin in DMA function gives the serial unit no clock.
module shared_pin_function_select (
	input  wire logic                        clock,          // System clock
	input  wire logic                        resetn,         // Async reset, active low
	input  wire logic [spfs_pkg::ADDR_W-1:0] regAddr,        // Register address
	input  wire logic [spfs_pkg::DATA_W-1:0] regWdata,       // Register write data
	input  wire logic                        regWrite,       // Write strobe
	input  wire logic                        regRead,        // Read strobe
	output logic      [spfs_pkg::DATA_W-1:0] regRdata,       // Read data, cycle after
	input  wire logic                        cpuAddr18,      // Core address bit 18
	input  wire logic                        cpuAddrOe,      // Core drives address bus
	input  wire logic                        timerPulseOut,  // Reload timer ch1 output
	input  wire logic                        ser0ClkOut,     // Serial 0 clock out
	input  wire logic                        ser0ClkOe,      // Serial 0 clock drive
	input  wire logic                        ser1ClkOut,     // Serial 1 clock out
	input  wire logic                        ser1ClkOe,      // Serial 1 clock drive
	input  wire logic                        dmaEndN,        // DMA ch0 transfer end, low
	output logic                             ser0ClkIn,      // Clock to serial 0
	output logic                             ser1ClkIn,      // Clock to serial 1
	output logic                             dma0RequestInN, // Request to DMA ch0, low
	output logic                             rxDataIn,       // Clocked serial rx data
	output logic                             ser1ClearToSendN, // CTS to serial 1, low
	input  wire logic                        addrPinIn,      // Unused sense of pin
	output logic                             addrPinOut,     // Address-18 pin drive
	output logic                             addrPinOe,      // Address-18 pin enable
	input  wire logic                        clk0PinIn,      // Serial-0 clock pin level
	output logic                             clk0PinOut,     // Serial-0 clock pin drive
	output logic                             clk0PinOe,      // Serial-0 clock pin enable
	input  wire logic                        clk1PinIn,      // Serial-1 clock pin level
	output logic                             clk1PinOut,     // Serial-1 clock pin drive
	output logic                             clk1PinOe,      // Serial-1 clock pin enable
	input  wire logic                        rxCtsPinIn      // Rx data / CTS pin level
);
	// ****************************************
	// Control bits and selections
	// ****************************************
	wire logic [spfs_pkg::DATA_W-1:0] timerCtrl;
	wire logic [spfs_pkg::DATA_W-1:0] dmaMode;
	wire logic [spfs_pkg::DATA_W-1:0] ser1Ctrl;
	wire logic [spfs_pkg::DATA_W-1:0] ser1Stat;
	wire logic                        timerOutCtrlHi;
	wire logic                        timerOutCtrlLo;
	wire logic                        dmaDestModeHi;
	wire logic                        dmaSrcModeHi;
	wire logic                        serial1ClockDisable;
	wire logic                        serial1CtsEnable;
	wire logic                        selTimer;
	wire logic                        selDreq;
	wire logic                        selTend;
	wire logic                        selCts;
	wire logic [3:0]                  pinState;
	wire logic                        unusedSense;

	assign timerOutCtrlHi      = timerCtrl[spfs_pkg::BIT_TOC_HI];
	assign timerOutCtrlLo      = timerCtrl[spfs_pkg::BIT_TOC_LO];
	assign dmaDestModeHi       = dmaMode[spfs_pkg::BIT_DMA_DEST];
	assign dmaSrcModeHi        = dmaMode[spfs_pkg::BIT_DMA_SRC];
	assign serial1ClockDisable = ser1Ctrl[spfs_pkg::BIT_CLK_DIS];
	assign serial1CtsEnable    = ser1Stat[spfs_pkg::BIT_CTS_EN];

	assign selTimer = timerOutCtrlHi | timerOutCtrlLo;  // [R01]
	assign selDreq  = dmaDestModeHi | dmaSrcModeHi;     // [R02]
	assign selTend  = serial1ClockDisable;              // [R03]
	assign selCts   = serial1CtsEnable;                 // [R04]
	assign pinState = {selCts, selTend, selDreq, selTimer};
	assign unusedSense = addrPinIn;

	// ****************************************
	// Register bank
	// ****************************************
	spfs_ctrl_bank uBank (
		.clock     (clock),
		.resetn    (resetn),
		.regAddr   (regAddr),
		.regWdata  (regWdata),
		.regWrite  (regWrite),
		.regRead   (regRead),
		.pinState  (pinState),
		.regRdata  (regRdata),
		.timerCtrl (timerCtrl),
		.dmaMode   (dmaMode),
		.ser1Ctrl  (ser1Ctrl),
		.ser1Stat  (ser1Stat)
	);

	// ****************************************
	// Address-18 / timer pin
	// ****************************************
	wire logic addrOutBase;
	wire logic addrOutAlt;
	wire logic addrOeBase;
	wire logic addrOeAlt;

	// Address bit follows the core; the sense pin never changes it
	assign addrOutBase = (cpuAddr18 & ~unusedSense) | cpuAddr18;
	assign addrOutAlt  = timerPulseOut;  // [R06]

	// Timer output drives regardless of bus release
	assign addrOeBase  = cpuAddrOe;
	assign addrOeAlt   = 1'h1;

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uAddrOut (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selTimer),     // [R01]
		.baseIn (addrOutBase),
		.altIn  (addrOutAlt),
		.q      (addrPinOut)
	);

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uAddrOe (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selTimer),     // [R01]
		.baseIn (addrOeBase),
		.altIn  (addrOeAlt),
		.q      (addrPinOe)
	);

	// ****************************************
	// Serial-0 clock / DMA request pin
	// ****************************************
	wire logic clk0OutBase;
	wire logic clk0OutAlt;
	wire logic clk0OeBase;
	wire logic clk0OeAlt;
	wire logic ser0InBase;
	wire logic ser0InAlt;
	wire logic dreqBase;
	wire logic dreqAlt;

	// Pin released while it carries the request
	assign clk0OutBase = ser0ClkOut;
	assign clk0OutAlt  = 1'h0;

	assign clk0OeBase  = ser0ClkOe;
	assign clk0OeAlt   = 1'h0;

	// Serial 0 sees a quiet clock while the pin is a request
	assign ser0InBase  = clk0PinIn;
	assign ser0InAlt   = 1'h0;       // [R07]

	// Request idles high while the pin serves as a clock
	assign dreqBase    = 1'h1;
	assign dreqAlt     = clk0PinIn;  // [R02]

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uClk0Out (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selDreq),      // [R02]
		.baseIn (clk0OutBase),
		.altIn  (clk0OutAlt),
		.q      (clk0PinOut)
	);

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uClk0Oe (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selDreq),      // [R02]
		.baseIn (clk0OeBase),
		.altIn  (clk0OeAlt),
		.q      (clk0PinOe)
	);

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uClk0In (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selDreq),      // [R07]
		.baseIn (ser0InBase),
		.altIn  (ser0InAlt),
		.q      (ser0ClkIn)
	);

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_HIGH)
	) uDreq (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selDreq),      // [R02]
		.baseIn (dreqBase),
		.altIn  (dreqAlt),
		.q      (dma0RequestInN)
	);

	// ****************************************
	// Serial-1 clock / transfer-end pin
	// ****************************************
	wire logic clk1OutBase;
	wire logic clk1OutAlt;
	wire logic clk1OeBase;
	wire logic clk1OeAlt;
	wire logic ser1InBase;
	wire logic ser1InAlt;

	assign clk1OutBase = ser1ClkOut;
	assign clk1OutAlt  = dmaEndN;    // [R05]

	// Transfer end owns the pin once selected
	assign clk1OeBase  = ser1ClkOe;
	assign clk1OeAlt   = 1'h1;

	// Serial 1 clock held low once the pin is cut
	assign ser1InBase  = clk1PinIn;
	assign ser1InAlt   = 1'h0;       // [R07]

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uClk1Out (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selTend),      // [R03]
		.baseIn (clk1OutBase),
		.altIn  (clk1OutAlt),
		.q      (clk1PinOut)
	);

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uClk1Oe (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selTend),      // [R03]
		.baseIn (clk1OeBase),
		.altIn  (clk1OeAlt),
		.q      (clk1PinOe)
	);

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uClk1In (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selTend),      // [R07]
		.baseIn (ser1InBase),
		.altIn  (ser1InAlt),
		.q      (ser1ClkIn)
	);

	// ****************************************
	// Receive data / clear-to-send pin
	// ****************************************
	wire logic rxBase;
	wire logic rxAlt;
	wire logic ctsBase;
	wire logic ctsAlt;

	// Unselected rx data sees its idle high; unselected CTS is held low, asserted
	assign rxBase  = rxCtsPinIn;
	assign rxAlt   = 1'h1;

	assign ctsBase = 1'h0;
	assign ctsAlt  = rxCtsPinIn;     // [R04]

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_HIGH)
	) uRxData (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selCts),       // [R04]
		.baseIn (rxBase),
		.altIn  (rxAlt),
		.q      (rxDataIn)
	);

	spfs_sel_reg #(
		.W     (1),
		.RST_Q (spfs_pkg::RST_LOW)
	) uCts (
		.clock  (clock),
		.resetn (resetn),
		.sel    (selCts),       // [R04]
		.baseIn (ctsBase),
		.altIn  (ctsAlt),
		.q      (ser1ClearToSendN)
	);
endmodule : shared_pin_function_select

// >>> logic/spfs_ctrl_bank.sv
// Control registers and read port of the pin selector
`timescale 1ns/1ps
module spfs_ctrl_bank (
	input  wire logic                          clock,      // System clock
	input  wire logic                          resetn,     // Async reset, active low
	input  wire logic [spfs_pkg::ADDR_W-1:0]   regAddr,    // Register address
	input  wire logic [spfs_pkg::DATA_W-1:0]   regWdata,   // Write data
	input  wire logic                          regWrite,   // Write strobe
	input  wire logic                          regRead,    // Read strobe
	input  wire logic [3:0]                    pinState,   // Current selections
	output logic      [spfs_pkg::DATA_W-1:0]   regRdata,   // Read data, cycle after
	output logic      [spfs_pkg::DATA_W-1:0]   timerCtrl,  // Timer output control
	output logic      [spfs_pkg::DATA_W-1:0]   dmaMode,    // DMA mode control
	output logic      [spfs_pkg::DATA_W-1:0]   ser1Ctrl,   // Serial 1 control
	output logic      [spfs_pkg::DATA_W-1:0]   ser1Stat    // Serial 1 status enable
);
	wire logic                        hitTmr;
	wire logic                        hitDma;
	wire logic                        hitCtl;
	wire logic                        hitSta;
	wire logic                        hitPin;
	wire logic [spfs_pkg::DATA_W-1:0] readMux;

	assign hitTmr = spfs_pkg::addr_hit(regAddr, spfs_pkg::OFS_TIMER_CTRL);
	assign hitDma = spfs_pkg::addr_hit(regAddr, spfs_pkg::OFS_DMA_MODE);
	assign hitCtl = spfs_pkg::addr_hit(regAddr, spfs_pkg::OFS_SER1_CTRL);
	assign hitSta = spfs_pkg::addr_hit(regAddr, spfs_pkg::OFS_SER1_STAT);
	assign hitPin = spfs_pkg::addr_hit(regAddr, spfs_pkg::OFS_PIN_STATE);

	// Unmapped addresses read as zero
	assign readMux = hitTmr ? timerCtrl :
		hitDma ? dmaMode :
		hitCtl ? ser1Ctrl :
		hitSta ? ser1Stat :
		hitPin ? {4'h0, pinState} : spfs_pkg::READ_ZERO;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			timerCtrl <= spfs_pkg::RST_REG;
			dmaMode   <= spfs_pkg::RST_REG;
			ser1Ctrl  <= spfs_pkg::RST_REG;
			ser1Stat  <= spfs_pkg::RST_REG;
			regRdata  <= spfs_pkg::READ_ZERO;
		end else begin
			if (regWrite && hitTmr) timerCtrl <= regWdata;
			if (regWrite && hitDma) dmaMode <= regWdata;
			if (regWrite && hitCtl) ser1Ctrl <= regWdata;
			if (regWrite && hitSta) ser1Stat <= regWdata;
			regRdata <= regRead ? readMux : spfs_pkg::READ_ZERO;
		end
	end
endmodule : spfs_ctrl_bank

// >>> logic/spfs_pkg.sv
// Constants for the shared pin function selector
package spfs_pkg;

	// ****************************************
	// Bus widths
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFS_TIMER_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DMA_MODE   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SER1_CTRL  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SER1_STAT  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PIN_STATE  = 8'h10;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_TOC_LO   = 0;
	localparam int BIT_TOC_HI   = 1;
	localparam int BIT_DMA_SRC  = 0;
	localparam int BIT_DMA_DEST = 1;
	localparam int BIT_CLK_DIS  = 0;
	localparam int BIT_CTS_EN   = 0;
	localparam int BIT_SEL_TMR  = 0;
	localparam int BIT_SEL_DREQ = 1;
	localparam int BIT_SEL_TEND = 2;
	localparam int BIT_SEL_CTS  = 3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [DATA_W-1:0] RST_REG   = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	localparam logic [1:0]        RST_PAIR0 = 2'h0;
	localparam logic              RST_HIGH  = 1'h1;
	localparam logic              RST_LOW   = 1'h0;

	// Address match, used by every register decode in spfs_ctrl_bank
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

endpackage : spfs_pkg

// >>> logic/spfs_sel_reg.sv
// Registered two-way selector, one per routed signal group
`timescale 1ns/1ps
module spfs_sel_reg #(
	parameter int           W     = 1,
	parameter logic [W-1:0] RST_Q = '0
) (
	input  wire logic         clock,   // System clock
	input  wire logic         resetn,  // Async reset, active low
	input  wire logic         sel,     // High picks the alternate group
	input  wire logic [W-1:0] baseIn,  // Default group
	input  wire logic [W-1:0] altIn,   // Alternate group
	output logic      [W-1:0] q        // Registered result
);
	wire logic [W-1:0] next_q;

	assign next_q = sel ? altIn : baseIn;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			q <= RST_Q;
		end else begin
			q <= next_q;
		end
	end
endmodule : spfs_sel_reg

// >>> test/shared_pin_function_select_tb.sv
// Self-checking bench for the shared pin selector
`timescale 1ns/1ps
module shared_pin_function_select_tb;
	localparam logic [7:0] OFS [4] = '{spfs_pkg::OFS_TIMER_CTRL, spfs_pkg::OFS_DMA_MODE,
		spfs_pkg::OFS_SER1_CTRL, spfs_pkg::OFS_SER1_STAT};
	logic        clock = 1'h0, resetn = 1'h0, regWrite = 1'h0, regRead = 1'h0, rdDue = 1'h0;
	logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata, cfg [4];
	logic        ser0ClkIn, ser1ClkIn, dma0RequestInN, rxDataIn, ser1ClearToSendN;
	logic        addrPinOut, addrPinOe, clk0PinOut, clk0PinOe, clk1PinOut, clk1PinOe;
	logic        cpuAddr18, cpuAddrOe, timerPulseOut, ser0ClkOut, ser0ClkOe, ser1ClkOut;
	logic        ser1ClkOe, dmaEndN, addrPinIn, rxCtsPinIn, board0, board1;
	logic [11:0] farBits;
	logic [7:0]  expQ [$];
	int          errTotal = 0, samplesChecked = 0;
	logic [3:0]  tbSel;
	logic [10:0] expPins;
	logic        pinDue = 1'h0;
	wire  [10:0] pins = {addrPinOut, addrPinOe, clk0PinOut, clk0PinOe, ser0ClkIn, dma0RequestInN,
		clk1PinOut, clk1PinOe, ser1ClkIn, rxDataIn, ser1ClearToSendN};
	// Pin level: design drive wins, else the board
	wire clk0PinIn = clk0PinOe ? clk0PinOut : board0;
	wire clk1PinIn = clk1PinOe ? clk1PinOut : board1;
	assign {addrPinIn, rxCtsPinIn, board1, board0, dmaEndN, ser1ClkOe, ser1ClkOut, ser0ClkOe,
		ser0ClkOut, timerPulseOut, cpuAddrOe, cpuAddr18} = farBits;
	shared_pin_function_select i_dut (.*);
	spfs_far_side i_far (.clock(clock), .resetn(resetn), .unitBits(farBits));
	always #5 clock = ~clock;
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errTotal++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic r, input logic [7:0] a, d, e);
		@(posedge clock);
		regWrite <= w;
		regRead  <= r;
		regAddr  <= a;
		regWdata <= d;
		if (r) expQ.push_back(e);
	endtask : bus
	task automatic finalReport;
		$display("Comparisons %0d, mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finalReport
	// ****************************************
	// Read-data and pin monitors
	// ****************************************
	always @(posedge clock) rdDue <= regRead;
	// Pin reference from last cycle's selections and unit levels
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tbSel   <= 4'h0;
			pinDue  <= 1'h0;
			expPins <= 11'h000;
		end else begin
			pinDue <= 1'h1;
			if (regWrite && regAddr == spfs_pkg::OFS_TIMER_CTRL) tbSel[0] <= |regWdata[1:0];
			if (regWrite && regAddr == spfs_pkg::OFS_DMA_MODE) tbSel[1] <= |regWdata[1:0];
			if (regWrite && regAddr == spfs_pkg::OFS_SER1_CTRL) tbSel[2] <= regWdata[0];
			if (regWrite && regAddr == spfs_pkg::OFS_SER1_STAT) tbSel[3] <= regWdata[0];
			expPins <= {tbSel[0] ? timerPulseOut : cpuAddr18, tbSel[0] | cpuAddrOe,
				~tbSel[1] & ser0ClkOut, ~tbSel[1] & ser0ClkOe, ~tbSel[1] & clk0PinIn,
				tbSel[1] ? clk0PinIn : 1'h1, tbSel[2] ? dmaEndN : ser1ClkOut,
				tbSel[2] | ser1ClkOe, ~tbSel[2] & clk1PinIn, tbSel[3] | rxCtsPinIn,
				tbSel[3] & rxCtsPinIn};
		end
	end
	always @(negedge clock) begin
		if (rdDue) check(regRdata, expQ.pop_front());
		if (pinDue) check({2'h0, pins[10:5]}, {2'h0, expPins[10:5]});
		if (pinDue) check({3'h0, pins[4:0]}, {3'h0, expPins[4:0]});
	end
	// ****************************************
	// Main sequence, second pass after a mid-run reset
	// ****************************************
	initial begin
		void'($urandom(32'hC3355F83));
		repeat (20) @(posedge clock);
		resetn <= 1'h1;
		for (int k = 0; k < 2; k++) begin
			foreach (OFS[i]) bus(1'h0, 1'h1, OFS[i], 8'h00, 8'h00);
			bus(1'h0, 1'h1, spfs_pkg::OFS_PIN_STATE, 8'h00, 8'h00);
			bus(1'h0, 1'h1, 8'h14, 8'h00, 8'h00);
			for (int n = 0; n < 16; n++) begin
				foreach (cfg[i]) cfg[i] = 8'($urandom);
				cfg[0][1:0] = 2'(n);
				cfg[1][1:0] = 2'(n >> 2);
				foreach (OFS[i]) bus(1'h1, 1'h0, OFS[i], cfg[i], 8'h00);
				bus(1'h1, 1'h0, spfs_pkg::OFS_PIN_STATE, 8'hFF, 8'h00);
				bus(1'h0, 1'h0, 8'h00, 8'h00, 8'h00);
				foreach (OFS[i]) bus(1'h0, 1'h1, OFS[i], 8'h00, cfg[i]);
				bus(1'h0, 1'h1, spfs_pkg::OFS_PIN_STATE, 8'h00,
					{4'h0, cfg[3][0], cfg[2][0], |cfg[1][1:0], |cfg[0][1:0]});
				repeat (6) bus(1'h0, 1'h0, 8'h00, 8'h00, 8'h00);
			end
			resetn <= 1'h0;
			repeat (3) @(posedge clock);
			resetn <= 1'h1;
		end
		repeat (2) @(posedge clock);
		finalReport();
	end
	initial begin
		#200000;
		errTotal++;
		finalReport();
	end
endmodule : shared_pin_function_select_tb

// >>> test/spfs_assertions.sv
// Concurrent checks on the ports of the shared pin selector
`timescale 1ns/1ps
module spfs_assertions (
	input wire logic                        clock,            // System clock
	input wire logic                        resetn,           // Async reset, active low
	input wire logic                        regWrite,         // Write strobe
	input wire logic [spfs_pkg::ADDR_W-1:0] regAddr,          // Register address
	input wire logic [spfs_pkg::DATA_W-1:0] regWdata,         // Write data
	input wire logic                        cpuAddr18,        // Core address bit 18
	input wire logic                        cpuAddrOe,        // Core drives address bus
	input wire logic                        timerPulseOut,    // Timer pulse
	input wire logic                        dmaEndN,          // Transfer end, low
	input wire logic                        ser0ClkOut,       // Serial 0 clock drive
	input wire logic                        ser0ClkOe,        // Serial 0 clock enable
	input wire logic                        ser1ClkOut,       // Serial 1 clock drive
	input wire logic                        ser1ClkOe,        // Serial 1 clock enable
	input wire logic                        clk0PinIn,        // Serial-0 clock pin level
	input wire logic                        clk1PinIn,        // Serial-1 clock pin level
	input wire logic                        rxCtsPinIn,       // Rx / CTS pin level
	input wire logic                        ser0ClkIn,        // Clock to serial 0
	input wire logic                        ser1ClkIn,        // Clock to serial 1
	input wire logic                        dma0RequestInN,   // Request to DMA, low
	input wire logic                        rxDataIn,         // Rx data to unit
	input wire logic                        ser1ClearToSendN, // CTS to serial 1, low
	input wire logic                        addrPinOut,       // Address pin drive
	input wire logic                        addrPinOe,        // Address pin enable
	input wire logic                        clk0PinOut,       // Serial-0 pin drive
	input wire logic                        clk0PinOe,        // Serial-0 pin enable
	input wire logic                        clk1PinOut,       // Serial-1 pin drive
	input wire logic                        clk1PinOe         // Serial-1 pin enable
);
	// ****************************************
	// Mirror of the selections
	// ****************************************
	logic warm, hTmr, hDreq, hTend, hCts;
	wire  wrTmr  = regWrite && (regAddr == spfs_pkg::OFS_TIMER_CTRL);
	wire  wrDma  = regWrite && (regAddr == spfs_pkg::OFS_DMA_MODE);
	wire  wrSer1 = regWrite && (regAddr == spfs_pkg::OFS_SER1_CTRL);
	wire  wrStat = regWrite && (regAddr == spfs_pkg::OFS_SER1_STAT);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{warm, hTmr, hDreq, hTend, hCts} <= 5'h00;
		end else begin
			warm <= 1'h1;
			if (wrTmr) hTmr <= |regWdata[1:0];
			if (wrDma) hDreq <= |regWdata[1:0];
			if (wrSer1) hTend <= regWdata[spfs_pkg::BIT_CLK_DIS];
			if (wrStat) hCts <= regWdata[spfs_pkg::BIT_CTS_EN];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// ****************************************
	// Pin routing
	// ****************************************
	AST_ADDR_PIN: assert property (warm |-> addrPinOut ==
		($past(hTmr) ? $past(timerPulseOut) : $past(cpuAddr18))) else $error("address pin wrong");
	AST_ADDR_OE: assert property (warm |-> addrPinOe == ($past(hTmr) | $past(cpuAddrOe)))
		else $error("address pin enable wrong");
	AST_DREQ: assert property (warm |-> dma0RequestInN ==
		($past(hDreq) ? $past(clk0PinIn) : 1'h1)) else $error("request input wrong");
	AST_SER0_CUT: assert property (warm && $past(hDreq) |-> !ser0ClkIn && !clk0PinOe)
		else $error("serial 0 clock not cut");
	AST_SER0_PASS: assert property (warm && !$past(hDreq) |-> ser0ClkIn == $past(clk0PinIn)
		&& clk0PinOut == $past(ser0ClkOut) && clk0PinOe == $past(ser0ClkOe))
		else $error("serial 0 clock path wrong");
	AST_TEND: assert property (warm && $past(hTend) |-> clk1PinOe && !ser1ClkIn
		&& clk1PinOut == $past(dmaEndN)) else $error("transfer end pin wrong");
	AST_SER1_PASS: assert property (warm && !$past(hTend) |-> ser1ClkIn == $past(clk1PinIn)
		&& clk1PinOut == $past(ser1ClkOut) && clk1PinOe == $past(ser1ClkOe))
		else $error("serial 1 clock path wrong");
	AST_CTS: assert property (warm |-> {ser1ClearToSendN, rxDataIn} == ($past(hCts) ?
		{$past(rxCtsPinIn), 1'h1} : {1'h0, $past(rxCtsPinIn)})) else $error("rx or cts wrong");
endmodule : spfs_assertions
bind shared_pin_function_select spfs_assertions i_chk (.*);

// >>> test/spfs_far_side.sv
// Model of the on-chip units and board pins around the selector
`timescale 1ns/1ps
module spfs_far_side (
	input  wire logic        clock,    // System clock
	input  wire logic        resetn,   // Sync reset, active low
	output logic      [11:0] unitBits  // Unit outputs and board pin drives
);
	// ****************************************
	// Unit and board levels
	// ****************************************
	// Fresh random levels every cycle out of reset, so a stale pass-through fails on any cycle where a level changes
	always @(posedge clock) begin
		unitBits <= resetn ? 12'($urandom) : 12'h0A5;
	end
endmodule : spfs_far_side
